/* core/retry_channel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "retry_defines.svh"
module retry_channel
(
   // Channel link.
   chan_if.chan c,
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset
);
   import retry_pkg::*;
   ch_state_t state_ff, nxt_state;
   retry_cnt_t cnt_ff, nxt_cnt;
   logic full_ff, nxt_full;
   logic [15:0] tmr_ff, nxt_tmr;
   logic odr_ff, nxt_odr;
   logic [15:0] period_us;
   logic cause, cause_now;

   // Retry when the selector matches the load type.
   assign c.retry_on = (c.retry_enable_bit == c.load_type);
   assign cause_now = c.oc | c.sc | c.ot | c.uv;
   // Temperature and supply faults must clear before retry begins.
   assign cause = c.oc | c.sc;
   assign period_us = 16'(`T_AUTO0_US + `T_AUTO_STEP_US * c.period_sel);
   assign c.chan_on = (state_ff == ch_normal);
   assign c.latched = (state_ff == ch_latched);
   assign c.full = full_ff;
   assign c.count = cnt_ff;
   assign c.oc_dur_reset = odr_ff;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_full = full_ff;
      nxt_tmr = tmr_ff;
      nxt_odr = 1'b0;
      case (state_ff)
         ch_normal:
         begin
            if (c.fc && cause_now)
            begin
               if (!c.retry_on)
                  nxt_state = ch_latched;
               else
               begin
                  nxt_state = ch_wait_clear;
                  nxt_tmr = 16'h0000;
               end
            end
         end
         ch_wait_clear:
         begin
            if (!(c.ot | c.uv))
               nxt_state = ch_retry_wait;
         end
         ch_retry_wait:
         begin
            if (c.tick_us)
               nxt_tmr = 16'(tmr_ff + 16'h0001);
            if (c.tick_us && tmr_ff + 16'h0001 >= period_us)
            begin
               if (c.unlimited)
                  nxt_state = ch_normal;
               else if (full_ff && cause)
                  nxt_state = ch_latched;
               else
               begin
                  nxt_state = ch_normal;
                  if (cnt_ff == `RETRY_CNT_MAX)
                     nxt_full = 1'b1;
                  else
                     nxt_cnt = 4'(cnt_ff + 4'h1);
                  if (!cnt_ff[0] || cnt_ff[0])
                     nxt_odr = !c.load_type;
               end
            end
         end
         ch_latched:
         begin
            if (c.delatch)
               nxt_state = ch_normal;
         end
         default:
            nxt_state = ch_normal;
      endcase
      if (c.load_type && c.pwm_off_no_oc)
         nxt_odr = 1'b1;
      if (c.cnt_clear)
      begin
         nxt_cnt = `RETRY_CNT_RST;
         nxt_full = 1'b0;
         if (state_ff == ch_latched && c.unlimited && c.retry_on)
         begin
            nxt_state = ch_retry_wait;
            nxt_tmr = 16'h0000;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= ch_normal;
         cnt_ff <= `RETRY_CNT_RST;
         full_ff <= 1'b0;
         tmr_ff <= 16'h0000;
         odr_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         full_ff <= nxt_full;
         tmr_ff <= nxt_tmr;
         odr_ff <= nxt_odr;
      end
   end
endmodule : retry_channel
`default_nettype wire

/* core/switch_autoretry_fault_diag.sv */
`timescale 1ns/100ps
`default_nettype none
`include "retry_defines.svh"
// Notes on behaviour
// - Logic-supply low, power supply rises above threshold: power-on flag set.
// - Entering wake with either supply up sets the power-on flag.
// - Power supply recovery with logic supply held up performs no reset.
// - Retry cause is overcurrent, severe short, overtemperature or undervoltage.
// - Undervoltage and overtemperature retries start only after the cause clears.
// - With retry disabled, latchable faults latch immediately.
// - Retry enabled when enable bit equals load type input.
// - Retry sequence starts on fault control high with retry cause.
// - Channel turns on again when the selected retry period expires.
// - Cause gone early: normal run, counter and fault bit kept.
// - Unlimited retry never latches the channel off.
// - Limited mode counts retries up to fifteen; the sixteenth retry sets the full bit.
// - Full bit set and fault persists at next retry: latch off, pin low.
// - Delatch turns the channel on without clearing the counter.
// - Counter readable in the retry word upper nibble in normal mode only.
// - Counter cleared on fail-safe, sleep exit, reset, unlimited, or disable.
// - Clear by unlimited delatches a latched channel after one period.
// - Lighting resets duration counter per limited-mode retry; motor on clean PWM off.
// - Diagnostic faults set their bit and never switch the channel off.
// - Each diagnostic has its own disable bit.
// - Off-state short to supply shown live on pin, bit sticky until read.
// - Open load off checked each off state, pin live, bit sticky.
// - Latched fault clears on fault word read after cause gone and delatch.
module switch_autoretry_fault_diag
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Supplies and modes.
   input wire logic pwr_above_por,
   input wire logic logic_above_por,
   input wire logic wake_reset_input_n,
   input wire logic [1:0] direct_input,
   input wire logic normal_mode,
   input wire logic failsafe_enter,
   input wire logic sleep_exit,
   // Faults and control per channel.
   input wire logic [1:0] overcurrent_fault,
   input wire logic [1:0] severe_short_fault,
   input wire logic [1:0] overtemp_fault,
   input wire logic undervoltage_fault,
   input wire logic [1:0] open_load_on_fault,
   input wire logic [1:0] open_load_off_fault,
   input wire logic [1:0] short_to_supply_fault,
   input wire logic [1:0] fault_control_signal,
   input wire logic [1:0] load_type_input,
   input wire logic [1:0] chan_off_state,
   input wire logic [1:0] pwm_off_no_oc,
   // Configuration.
   input wire logic [1:0] retry_enable_bit,
   input wire logic [1:0] unlimited_bit,
   input wire retry_pkg::period_sel_t period_sel0,
   input wire retry_pkg::period_sel_t period_sel1,
   input wire logic [1:0] open_load_on_disable,
   input wire logic [1:0] open_load_off_disable,
   input wire logic [1:0] short_to_supply_disable,
   input wire logic [1:0] delatch,
   input wire logic [1:0] fault_word_read,
   input wire logic status_read,
   // Outputs.
   output logic [1:0] chan_on,
   output logic [1:0] oc_dur_reset,
   output logic fault_pin_n,
   output logic [7:0] device_status_word,
   output logic [7:0] retry_word0,
   output logic [7:0] retry_word1,
   output logic [3:0] channel_fault_word0,
   output logic [3:0] channel_fault_word1
);
   import retry_pkg::*;
   logic [1:0] sup_ff, nxt_sup;
   logic awake_ff, nxt_awake;
   logic por_ff, nxt_por;
   logic [6:0] div_ff, nxt_div;
   logic tick_ff, nxt_tick;
   logic [1:0] en_ff, nxt_en;
   logic [1:0] unl_ff, nxt_unl;
   logic [3:0] fw_ff [2];
   logic [3:0] nxt_fw [2];
   logic [7:0] rw_ff [2];
   logic [7:0] nxt_rw [2];
   logic [1:0] on_ff, nxt_on, odr_ff, nxt_odr, full_ff, nxt_full;
   logic pin_ff, nxt_pin;
   logic awake, por_evt;
   logic [1:0] live, clr, rtr_on, latched, ch_on, ch_full, ch_odr;
   retry_cnt_t cnt [2];
   period_sel_t psel [2];

   chan_if cif [2] ();
   assign psel[0] = period_sel0;
   assign psel[1] = period_sel1;
   assign awake = ~wake_reset_input_n | (|direct_input);

   // Power-on event from supply edges and wake entry.
   always_comb
   begin
      nxt_sup = {pwr_above_por, logic_above_por};
      nxt_awake = awake;
      por_evt = 1'b0;
      if (awake && pwr_above_por && !sup_ff[1] && !logic_above_por)
         por_evt = 1'b1;
      if (awake && logic_above_por && !sup_ff[0] && !pwr_above_por)
         por_evt = 1'b1;
      if (awake && !awake_ff && (pwr_above_por || logic_above_por))
         por_evt = 1'b1;
      // A supply return with the logic supply steady up is no event.
      nxt_por = por_evt | (por_ff & ~status_read);
      nxt_div = (div_ff == 7'(`CLK_MHZ - 1)) ? 7'h00 : 7'(div_ff + 7'h01);
      nxt_tick = (div_ff == 7'h00);
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : ch
         assign cif[g].oc = overcurrent_fault[g];
         assign cif[g].sc = severe_short_fault[g];
         assign cif[g].ot = overtemp_fault[g];
         assign cif[g].uv = undervoltage_fault;
         assign cif[g].fc = fault_control_signal[g];
         assign cif[g].unlimited = unlimited_bit[g];
         assign cif[g].retry_enable_bit = retry_enable_bit[g];
         assign cif[g].period_sel = psel[g];
         assign cif[g].delatch = delatch[g];
         assign cif[g].cnt_clear = clr[g];
         assign cif[g].load_type = load_type_input[g];
         assign cif[g].tick_us = tick_ff;
         assign cif[g].pwm_off_no_oc = pwm_off_no_oc[g];
         assign rtr_on[g] = cif[g].retry_on;
         assign ch_on[g] = cif[g].chan_on;
         assign latched[g] = cif[g].latched;
         assign ch_full[g] = cif[g].full;
         assign cnt[g] = cif[g].count;
         assign ch_odr[g] = cif[g].oc_dur_reset;
         retry_channel u_chan
         (
            .c(cif[g].chan),
            .sys_clk(sys_clk),
            .reset(reset)
         );
         // Counter clear events.
         assign clr[g] = failsafe_enter | sleep_exit | por_evt
            | (unlimited_bit[g] & ~unl_ff[g])
            | (en_ff[g] & ~rtr_on[g]);
         // Live diagnostics in off state only, each individually gated.
         assign live[g] = chan_off_state[g] & ((short_to_supply_fault[g]
            & ~short_to_supply_disable[g]) | (open_load_off_fault[g]
            & ~open_load_off_disable[g]));
      end
   endgenerate

   always_comb
   begin
      nxt_en = rtr_on;
      nxt_unl = unlimited_bit;
      nxt_on = ch_on;
      nxt_odr = ch_odr;
      nxt_full = ch_full;
      // Pin follows live faults and latched channels; high once clear.
      nxt_pin = ~(|live | |latched | (|(open_load_on_fault
         & ~open_load_on_disable & ~chan_off_state)));
      for (int i = 0; i < 2; i++)
      begin
         nxt_fw[i] = fw_ff[i];
         // Set wins over the read clear.
         if (fault_word_read[i])
         begin
            nxt_fw[i][`FLT_OS_BIT] = 1'b0;
            nxt_fw[i][`FLT_OPEN_LOAD_OFF_FAULT_BIT] = 1'b0;
            nxt_fw[i][`FLT_OPEN_LOAD_ON_FAULT_BIT] = 1'b0;
            if (!latched[i] && !(overcurrent_fault[i] | severe_short_fault[i]
               | overtemp_fault[i] | undervoltage_fault))
               nxt_fw[i][`FLT_LATCH_BIT] = 1'b0;
         end
         if (chan_off_state[i] && short_to_supply_fault[i]
            && !short_to_supply_disable[i])
            nxt_fw[i][`FLT_OS_BIT] = 1'b1;
         if (chan_off_state[i] && open_load_off_fault[i]
            && !open_load_off_disable[i])
            nxt_fw[i][`FLT_OPEN_LOAD_OFF_FAULT_BIT] = 1'b1;
         if (open_load_on_fault[i] && !open_load_on_disable[i]
            && !chan_off_state[i])
            nxt_fw[i][`FLT_OPEN_LOAD_ON_FAULT_BIT] = 1'b1;
         if (fault_control_signal[i] && (overcurrent_fault[i]
            | severe_short_fault[i] | overtemp_fault[i]
            | undervoltage_fault))
            nxt_fw[i][`FLT_LATCH_BIT] = 1'b1;
         nxt_rw[i] = 8'h00;
         if (normal_mode)
            nxt_rw[i][7:`RDW_CNT_LSB] = cnt[i];
         nxt_rw[i][0] = retry_enable_bit[i];
         nxt_rw[i][1] = unlimited_bit[i];
         nxt_rw[i][3:2] = psel[i];
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         sup_ff <= 2'h0;
         awake_ff <= 1'b0;
         por_ff <= 1'b1;
         div_ff <= 7'h00;
         tick_ff <= 1'b0;
         en_ff <= 2'h0;
         unl_ff <= 2'h0;
         on_ff <= 2'h3;
         odr_ff <= 2'h0;
         full_ff <= 2'h0;
         pin_ff <= 1'b1;
         for (int i = 0; i < 2; i++)
         begin
            fw_ff[i] <= 4'h0;
            rw_ff[i] <= 8'h00;
         end
      end
      else
      begin
         sup_ff <= nxt_sup;
         awake_ff <= nxt_awake;
         por_ff <= nxt_por;
         div_ff <= nxt_div;
         tick_ff <= nxt_tick;
         en_ff <= nxt_en;
         unl_ff <= nxt_unl;
         on_ff <= nxt_on;
         odr_ff <= nxt_odr;
         full_ff <= nxt_full;
         pin_ff <= nxt_pin;
         for (int i = 0; i < 2; i++)
         begin
            fw_ff[i] <= nxt_fw[i];
            rw_ff[i] <= nxt_rw[i];
         end
      end
   end

   assign chan_on = on_ff;
   assign oc_dur_reset = odr_ff;
   assign fault_pin_n = pin_ff;
   assign retry_word0 = rw_ff[0];
   assign retry_word1 = rw_ff[1];
   assign channel_fault_word0 = fw_ff[0];
   assign channel_fault_word1 = fw_ff[1];
   assign device_status_word = {1'b0, por_ff, full_ff, 4'h0};
endmodule : switch_autoretry_fault_diag
`default_nettype wire

/* include/chan_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface chan_if;
   import retry_pkg::*;
   logic oc;
   logic sc;
   logic ot;
   logic uv;
   logic fc;
   logic retry_on;
   logic unlimited;
   logic retry_enable_bit;
   period_sel_t period_sel;
   logic delatch;
   logic cnt_clear;
   logic load_type;
   logic tick_us;
   logic chan_on;
   logic latched;
   logic full;
   logic oc_dur_reset;
   logic pwm_off_no_oc;
   retry_cnt_t count;
   modport top (output oc, sc, ot, uv, fc, unlimited, retry_enable_bit,
      period_sel, delatch, cnt_clear, load_type, tick_us, pwm_off_no_oc,
      input retry_on, chan_on, latched, full, count, oc_dur_reset);
   modport chan (input oc, sc, ot, uv, fc, unlimited, retry_enable_bit,
      period_sel, delatch, cnt_clear, load_type, tick_us, pwm_off_no_oc,
      output retry_on, chan_on, latched, full, count, oc_dur_reset);
endinterface : chan_if
`default_nettype wire

/* include/retry_defines.svh */
`ifndef RETRY_DEFINES_SVH
`define RETRY_DEFINES_SVH

`define RETRY_CNT_MAX 4'hf
`define RETRY_CNT_RST 4'h0
`define PERIOD_SEL_W 2
`define T_AUTO0_US 16'h0100
`define T_AUTO_STEP_US 16'h0100
`define CLK_MHZ 16'h0064
`define STAT_POR_BIT 6
`define STAT_FULL0_BIT 4
`define STAT_FULL1_BIT 5
`define RDW_CNT_LSB 4
`define FLT_OS_BIT 0
`define FLT_OPEN_LOAD_OFF_FAULT_BIT 1
`define FLT_OPEN_LOAD_ON_FAULT_BIT 2
`define FLT_LATCH_BIT 3

`endif

/* include/retry_pkg.sv */
package retry_pkg;
   typedef enum {
      ch_normal,
      ch_wait_clear,
      ch_retry_wait,
      ch_latched
   } ch_state_t;
   typedef logic [3:0] retry_cnt_t;
   typedef logic [1:0] period_sel_t;
endpackage : retry_pkg

/* verification/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   // Clock.
   input wire logic sys_clk,
   // Host strobes.
   output logic status_read,
   output logic [1:0] fault_word_read,
   output logic [1:0] delatch
);
   initial
   begin
      {status_read, fault_word_read, delatch} = 5'h00;
   end
   // Sends one-cycle strobes: {status, read[1:0], delatch[1:0]}.
   task automatic pulse(input logic [4:0] s);
      @(posedge sys_clk);
      {status_read, fault_word_read, delatch} <= s;
      @(posedge sys_clk);
      {status_read, fault_word_read, delatch} <= 5'h00;
   endtask : pulse
endmodule : host_model
`default_nettype wire

/* verification/switch_autoretry_fault_diag_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module fault_retry_chk
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Watched inputs.
   input wire logic normal_mode, undervoltage_fault, failsafe_enter,
   input wire logic wake_reset_input_n,
   input wire logic [1:0] overcurrent_fault, severe_short_fault,
   input wire logic [1:0] overtemp_fault, fault_control_signal,
   input wire logic [1:0] load_type_input, retry_enable_bit, unlimited_bit,
   input wire logic [1:0] short_to_supply_fault, short_to_supply_disable,
   input wire logic [1:0] chan_off_state, fault_word_read,
   // Watched outputs.
   input wire logic fault_pin_n,
   input wire logic [1:0] chan_on,
   input wire logic [7:0] retry_word0,
   input wire logic [3:0] channel_fault_word0, channel_fault_word1
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_os_set: assert property (
      (short_to_supply_fault[0] && chan_off_state[0] &&
      !short_to_supply_disable[0]) |-> ##[1:3] channel_fault_word0[0])
      else $error("short bit not set");
   a_os_sticky: assert property (
      channel_fault_word0[0] && !fault_word_read[0] |=> channel_fault_word0[0])
      else $error("short bit lost");
   a_os_disabled: assert property (
      (short_to_supply_disable[0] && !channel_fault_word0[0])[*3]
      |=> !channel_fault_word0[0]) else $error("disabled bit set");
   a_pin_live: assert property (
      (short_to_supply_fault[0] && chan_off_state[0] &&
      !short_to_supply_disable[0])[*2] |=> !fault_pin_n)
      else $error("fault pin not low");
   a_dis_latch: assert property (
      (retry_enable_bit[1] != load_type_input[1]) && fault_control_signal[1]
      && (overcurrent_fault[1] || severe_short_fault[1] || overtemp_fault[1])
      |-> ##[1:4] (!chan_on[1] && channel_fault_word1[3]))
      else $error("fault not latched");
   a_cnt_hidden: assert property (
      !normal_mode |=> retry_word0[7:4] == 4'h0) else $error("count shown");
   a_unl_clears: assert property (
      $rose(unlimited_bit[0]) ##0 normal_mode[*3] |-> retry_word0[7:4] == 4'h0)
      else $error("count not cleared");
   a_cnt_step: assert property (
      normal_mode[*3] ##0 $changed(retry_word0[7:4]) |-> retry_word0[7:4]
      inside {4'h0, $past(retry_word0[7:4]) + 4'h1})
      else $error("count jumped");
   a_diag_on: assert property (
      (!(overcurrent_fault[0] | severe_short_fault[0] | overtemp_fault[0]) &&
      !undervoltage_fault && !wake_reset_input_n && !failsafe_enter)[*3]
      ##0 chan_on[0] |=> chan_on[0]) else $error("channel dropped");
endmodule : fault_retry_chk
bind switch_autoretry_fault_diag fault_retry_chk u_chk (.sys_clk, .reset,
   .normal_mode, .undervoltage_fault, .failsafe_enter, .wake_reset_input_n,
   .overcurrent_fault, .severe_short_fault, .overtemp_fault,
   .fault_control_signal, .load_type_input, .retry_enable_bit, .unlimited_bit,
   .short_to_supply_fault, .short_to_supply_disable, .chan_off_state,
   .fault_word_read, .fault_pin_n, .chan_on, .retry_word0,
   .channel_fault_word0, .channel_fault_word1);
`default_nettype wire

/* verification/test_switch_autoretry_fault_diag.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
   begin \
      checks++; \
      if ((s) !== (e)) \
      begin \
         n_errors++; \
         $display("unexpected %s expected %h seen %h", n, e, s); \
      end \
   end
module test_switch_autoretry_fault_diag;
   import retry_pkg::*;
   logic sys_clk = 1'h0, reset = 1'h1, pwr_above_por = 1'h1;
   logic logic_above_por = 1'h1, wake_reset_input_n = 1'h0;
   logic normal_mode = 1'h1, failsafe_enter = 1'h0, sleep_exit = 1'h0;
   logic undervoltage_fault = 1'h0, status_read, fault_pin_n;
   logic [1:0] direct_input = 2'h0, overcurrent_fault = 2'h0;
   logic [1:0] severe_short_fault = 2'h0, overtemp_fault = 2'h0;
   logic [1:0] open_load_on_fault = 2'h0, open_load_off_fault = 2'h0;
   logic [1:0] short_to_supply_fault = 2'h0, fault_control_signal = 2'h0;
   logic [1:0] load_type_input = 2'h2, chan_off_state = 2'h0;
   logic [1:0] pwm_off_no_oc = 2'h0, retry_enable_bit = 2'h0;
   logic [1:0] unlimited_bit = 2'h0, open_load_on_disable = 2'h0;
   logic [1:0] open_load_off_disable = 2'h0, short_to_supply_disable = 2'h0;
   logic [1:0] delatch, fault_word_read, chan_on, oc_dur_reset;
   period_sel_t period_sel0 = 2'h0, period_sel1 = 2'h3;
   logic [7:0] device_status_word, retry_word0, retry_word1;
   logic [3:0] channel_fault_word0, channel_fault_word1;
   logic seen_on, seen_rst;
   int n_errors = 0, checks = 0;
   // Rows: {unused, open_load_off_fault, os faults}, {open_load_on_fault, open_load_off_fault, os disables}, word.
   logic [8:0] rows [5] = '{9'o101, 9'o202, 9'o330, 9'o312, 9'o321};
   switch_autoretry_fault_diag DUT (.*);
   host_model H (.*);
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt
   task automatic sup(input logic p, input logic l, input logic w);
      pwr_above_por = p;
      logic_above_por = l;
      wake_reset_input_n = w;
      wt(3);
   endtask : sup
   task automatic conclude;
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
   initial
   begin
      wt(2);
      reset = 1'h0;
      wt(1);
      `CHK("por", 1'h1, device_status_word[6])
      `CHK("chan_on", 2'h3, chan_on)
      `CHK("sel1", 2'h3, retry_word1[3:2])
      H.pulse(5'h10);
      wt(2);
      sup(1'h0, 1'h1, 1'h0);
      sup(1'h1, 1'h1, 1'h0);
      `CHK("por", 1'h0, device_status_word[6])
      sup(1'h0, 1'h0, 1'h0);
      sup(1'h1, 1'h0, 1'h0);
      `CHK("por", 1'h1, device_status_word[6])
      H.pulse(5'h10);
      wt(2);
      sup(1'h1, 1'h1, 1'h1);
      sup(1'h1, 1'h1, 1'h0);
      `CHK("por", 1'h1, device_status_word[6])
      H.pulse(5'h10);
      wt(3);
      chan_off_state = 2'h3;
      foreach (rows[i])
      begin
         open_load_off_fault = {2{rows[i][7]}};
         short_to_supply_fault = {2{rows[i][6]}};
         {open_load_on_disable, open_load_off_disable} =
            {{2{rows[i][5]}}, {2{rows[i][4]}}};
         short_to_supply_disable = {2{rows[i][3]}};
         wt(3);
         `CHK("word0", {1'h0, rows[i][2:0]}, channel_fault_word0)
         `CHK("word1", {1'h0, rows[i][2:0]}, channel_fault_word1)
         `CHK("pin", rows[i][2:0] == 3'h0, fault_pin_n)
         `CHK("chan_on", 2'h3, chan_on)
         {open_load_off_fault, short_to_supply_fault} = 4'h0;
         wt(3);
         `CHK("pin", 1'h1, fault_pin_n)
         `CHK("sticky", {1'h0, rows[i][2:0]}, channel_fault_word0)
         H.pulse(5'h0c);
         wt(2);
         `CHK("cleared", 4'h0, channel_fault_word0)
      end
      chan_off_state = 2'h0;
      fault_control_signal = 2'h3;
      overcurrent_fault = 2'h1;
      wt(4);
      `CHK("chan_on", 2'h2, chan_on)
      overcurrent_fault = 2'h0;
      wt(25500);
      `CHK("wait", 1'h0, chan_on[0])
      {seen_on, seen_rst} = 2'h0;
      repeat (24)
      begin
         wt(1);
         seen_on |= chan_on[0];
         seen_rst |= oc_dur_reset[0];
      end
      `CHK("retry_on", 1'h1, seen_on)
      `CHK("dur_reset", 1'h1, seen_rst)
      `CHK("count", 4'h1, retry_word0[7:4])
      `CHK("fault_bit", 1'h1, channel_fault_word0[3])
      `CHK("pin", 1'h1, fault_pin_n)
      normal_mode = 1'h0;
      wt(2);
      `CHK("hidden", 4'h0, retry_word0[7:4])
      normal_mode = 1'h1;
      wt(2);
      `CHK("count", 4'h1, retry_word0[7:4])
      {severe_short_fault, overtemp_fault} = 4'ha;
      wt(4);
      `CHK("latched", 1'h0, chan_on[1])
      `CHK("pin", 1'h0, fault_pin_n)
      `CHK("latch_bit", 1'h1, channel_fault_word1[3])
      wt(40);
      `CHK("latched", 1'h0, chan_on[1])
      {severe_short_fault, overtemp_fault} = 4'h0;
      H.pulse(5'h02);
      wt(3);
      `CHK("delatched", 1'h1, chan_on[1])
      `CHK("count", 4'h1, retry_word0[7:4])
      H.pulse(5'h08);
      wt(2);
      `CHK("latch_bit", 1'h0, channel_fault_word1[3])
      failsafe_enter = 1'h1;
      wt(1);
      failsafe_enter = 1'h0;
      wt(2);
      `CHK("count", 4'h0, retry_word0[7:4])
      unlimited_bit = 2'h1;
      wt(4);
      `CHK("unl", 1'h1, retry_word0[1])
      pwm_off_no_oc = 2'h3;
      wt(1);
      pwm_off_no_oc = 2'h0;
      wt(1);
      `CHK("motor_reset", 2'h2, oc_dur_reset)
      open_load_on_fault = 2'h1;
      wt(3);
      `CHK("open_load_on_fault_bit", 1'h1, channel_fault_word0[2])
      `CHK("pin", 1'h0, fault_pin_n)
      `CHK("chan_on", 1'h1, chan_on[0])
      open_load_on_fault = 2'h0;
      wt(3);
      `CHK("pin", 1'h1, fault_pin_n)
      H.pulse(5'h04);
      wt(2);
      `CHK("open_load_on_fault_clr", 1'h0, channel_fault_word0[2])
      sleep_exit = 1'h1;
      wt(1);
      sleep_exit = 1'h0;
      wt(2);
      `CHK("count", 4'h0, retry_word0[7:4])
      H.pulse(5'h10);
      wt(2);
      sup(1'h1, 1'h1, 1'h1);
      direct_input = 2'h2;
      wt(3);
      `CHK("por", 1'h1, device_status_word[6])
      conclude();
   end
endmodule : test_switch_autoretry_fault_diag
`default_nettype wire
